//--- verilog/xlate_pkg.sv
package xlate_pkg;
  localparam int unsigned TBL_ENTRIES  = 4096;
  localparam logic [31:0] TBL_BASE     = 32'h0000_8000;
  localparam logic [31:0] TBL_LAST     = 32'h0000_bfff;
  localparam logic [31:0] IRQ_STAT_OFS = 32'h0004_0000;
  localparam logic [31:0] IRQ_MASK_OFS = 32'h0004_0004;
  localparam int unsigned IDX_LSB      = 2;
  localparam int unsigned PAGE_LSB     = 12;
  localparam int unsigned LINK_IDX_LSB = 12;
  localparam int unsigned INVALID_BIT  = 0;
  localparam int unsigned SWAP_NB_BIT  = 1;
  localparam int unsigned WSWAP_BIT    = 2;
  localparam int unsigned SWAP_B_BIT   = 3;
  localparam int unsigned EV_DONE      = 0;
  localparam int unsigned EV_BERR      = 1;
  localparam int unsigned EV_W         = 2;
  localparam logic [1:0]  STAT_RST     = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} xfer_size_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    xfer_size_t  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } link_req_t;

  typedef struct packed {
    logic        ack;
    logic        berr;
    logic [31:0] rdata;
  } link_rsp_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pci_req_t;

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } pci_rsp_t;

  typedef struct packed {
    logic [19:0] page;
    logic        swap_b;
    logic        wswap;
    logic        swap_nb;
    logic        invalid;
  } map_entry_t;
endpackage

//--- verilog/page_xlate.sv
// What this block does
// RULE1 - 4,096 entries, each maps one 4 Kbyte page, 16 Mbyte total.
// RULE2 - The cable side forwards the full VME address for every access.
// RULE3 - VME address bits 11..0 pass unchanged to PCI address bits 11..0.
// RULE4 - VME address bits 23..12 index the table, whatever the window base.
// RULE5 - The entry supplies PCI address bits 31..12 and swap controls.
// RULE6 - PCI access is made at the composed address; read data returns.
// RULE7 - Table sits at 0x8000..0xbfff, one word per entry, index order.
// RULE8 - Entry bit 0 set ends the access with a bus error instead.
// RULE9 - Invalid flag is undefined after power-up until written.
// RULE10 - Entry bit 1 swaps bytes on 16-bit and 32-bit transfers.
// RULE11 - Entry bit 2 inverts address bit 1 on 16-bit transfers.
// RULE12 - Entry bit 3 byte-swaps single-byte transfers.
// RULE13 - Entry bits 4..11 have no effect on translation.
// RULE14 - PCI address is entry bits 31..12 joined to VME bits 11..0.
// RULE15 - VME window base should sit on a 16 Mbyte boundary.
// RULE16 - Each entry reads and writes as a word; reserved bits dropped.
// RULE17 - One inbound access completes before the next is taken.
`timescale 1ns/100ps
`default_nettype none
module page_xlate (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire xlate_pkg::link_req_t link_in,
  output logic                      link_ready,
  output xlate_pkg::link_rsp_t      link_out,
  output xlate_pkg::pci_req_t       pci_out,
  input  wire xlate_pkg::pci_rsp_t  pci_in,
  output logic                      irq
);
  import xlate_pkg::*;

  typedef enum logic {ST_IDLE, ST_PCI} fsm_t;

  typedef struct packed {
    map_entry_t [TBL_ENTRIES-1:0] tbl;
    fsm_t                         fsm;
    logic                         dph_tbl;
    logic                         dph_stat;
    logic                         dph_mask;
    logic [11:0]                  dph_idx;
    logic [31:0]                  hrdata;
    logic                         hready_o;
    logic                         hresp;
    logic [EV_W-1:0]              status;
    logic [EV_W-1:0]              mask;
    logic                         irq;
    logic                         link_ready;
    link_rsp_t                    lrsp;
    pci_req_t                     preq;
    xfer_size_t                   sz;
    map_entry_t                   ent;
  } state_t;

  state_t     st_r;
  state_t     st_nxt;
  logic       take;
  map_entry_t lk_ent;

  function automatic map_entry_t to_entry(input logic [31:0] d);
    map_entry_t e;
    e.page    = d[31:PAGE_LSB];
    e.swap_b  = d[SWAP_B_BIT];
    e.wswap   = d[WSWAP_BIT];
    e.swap_nb = d[SWAP_NB_BIT];
    e.invalid = d[INVALID_BIT];
    return e;
  endfunction

  // Bits 11..4 are not stored at all, so they read back as zero
  function automatic logic [31:0] from_entry(input map_entry_t e);
    return {e.page, 8'h00, e.swap_b, e.wswap, e.swap_nb, e.invalid}; // [RULE13]
  endfunction

  function automatic logic [31:0] swap_half(input logic [31:0] d);
    return {d[23:16], d[31:24], d[7:0], d[15:8]};
  endfunction

  // Each swap is its own inverse, so reads reuse it on the way back
  function automatic logic [31:0] swap_data(input logic [31:0] d,
                                            input xfer_size_t  sz,
                                            input map_entry_t  e);
    logic [31:0] r;
    r = d;
    case (sz)
      SZ_BYTE: begin
        if (e.swap_b) begin
          r = swap_half(d); // [RULE12]
        end
      end
      SZ_WORD: begin
        if (e.swap_nb) begin
          r = swap_half(r); // [RULE10]
        end
        if (e.wswap) begin
          r = {r[15:0], r[31:16]}; // [RULE11]
        end
      end
      SZ_LONG: begin
        if (e.swap_nb) begin
          r = {d[7:0], d[15:8], d[23:16], d[31:24]}; // [RULE10]
        end
      end
      default: r = d;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] xl_addr(input logic [31:0] a,
                                          input xfer_size_t  sz,
                                          input map_entry_t  e);
    logic [31:0] p;
    p = {e.page, a[PAGE_LSB-1:0]}; // [RULE3] [RULE5] [RULE14]
    if (sz == SZ_WORD && e.wswap) begin
      p[1] = ~p[1]; // [RULE11]
    end
    if (sz == SZ_BYTE && e.swap_b) begin
      p[0] = ~p[0]; // [RULE12]
    end
    return p;
  endfunction

  function automatic logic [3:0] lane_be(input logic [1:0] a, input xfer_size_t sz);
    logic [3:0] b;
    case (sz)
      SZ_BYTE: b = 4'h1 << a;
      SZ_WORD: b = a[1] ? 4'hc : 4'h3;
      default: b = 4'hf;
    endcase
    return b;
  endfunction

  always_comb begin
    logic            acc;
    logic [EV_W-1:0] ev;
    logic [11:0]     aidx;
    logic [31:0]     pa;
    acc    = hsel && htrans[1] && hready;
    ev     = '0;
    aidx   = haddr[IDX_LSB +: 12];
    pa     = '0;
    st_nxt = st_r;
    st_nxt.lrsp.ack  = 1'b0;
    st_nxt.lrsp.berr = 1'b0;
    st_nxt.hready_o  = 1'b1;
    st_nxt.hresp     = 1'b0;
    // Data phase of a write
    if (st_r.dph_tbl) begin
      st_nxt.tbl[st_r.dph_idx] = to_entry(hwdata); // [RULE16] [RULE7]
    end
    if (st_r.dph_stat) begin
      st_nxt.status = st_r.status & ~hwdata[EV_W-1:0];
    end
    if (st_r.dph_mask) begin
      st_nxt.mask = hwdata[EV_W-1:0];
    end
    // Address phase; reads see a write finishing in this same cycle
    st_nxt.dph_tbl  = acc && hwrite && haddr >= TBL_BASE && haddr <= TBL_LAST;
    st_nxt.dph_stat = acc && hwrite && haddr == IRQ_STAT_OFS;
    st_nxt.dph_mask = acc && hwrite && haddr == IRQ_MASK_OFS;
    st_nxt.dph_idx  = aidx;
    if (acc && !hwrite) begin
      if (haddr >= TBL_BASE && haddr <= TBL_LAST) begin
        st_nxt.hrdata = from_entry(st_nxt.tbl[aidx]); // [RULE16] [RULE7]
      end else if (haddr == IRQ_STAT_OFS) begin
        st_nxt.hrdata = {30'h0, st_nxt.status};
      end else if (haddr == IRQ_MASK_OFS) begin
        st_nxt.hrdata = {30'h0, st_nxt.mask};
      end else begin
        st_nxt.hrdata = 32'h0;
      end
    end
    // Inbound link, one access at a time
    take   = link_in.valid && st_r.link_ready; // [RULE17]
    lk_ent = st_nxt.tbl[link_in.addr[LINK_IDX_LSB +: 12]]; // [RULE4] [RULE2] [RULE1]
    case (st_r.fsm)
      ST_IDLE: begin
        st_nxt.link_ready = 1'b1;
        if (take) begin
          if (lk_ent.invalid) begin
            st_nxt.lrsp.berr = 1'b1; // [RULE8]
            ev[EV_BERR]      = 1'b1;
          end else begin
            pa = xl_addr(link_in.addr, link_in.size, lk_ent);
            st_nxt.preq.req   = 1'b1; // [RULE6]
            st_nxt.preq.write = link_in.write;
            st_nxt.preq.addr  = pa;
            st_nxt.preq.be    = lane_be(pa[1:0], link_in.size);
            st_nxt.preq.wdata = swap_data(link_in.wdata, link_in.size, lk_ent);
            st_nxt.sz         = link_in.size;
            st_nxt.ent        = lk_ent;
            st_nxt.link_ready = 1'b0; // [RULE17]
            st_nxt.fsm        = ST_PCI;
          end
        end
      end
      ST_PCI: begin
        if (pci_in.done) begin
          st_nxt.preq.req   = 1'b0;
          st_nxt.lrsp.ack   = 1'b1;
          if (!st_r.preq.write) begin
            st_nxt.lrsp.rdata = swap_data(pci_in.rdata, st_r.sz, st_r.ent); // [RULE6]
          end
          ev[EV_DONE]       = 1'b1;
          st_nxt.link_ready = 1'b1;
          st_nxt.fsm        = ST_IDLE;
        end
      end
      default: st_nxt.fsm = ST_IDLE;
    endcase
    // Set wins over a clear in the same cycle
    st_nxt.status = st_nxt.status | ev;
    st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
  end

  // Table has no reset: entries stay unknown until software writes them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r.fsm        <= ST_IDLE;
      st_r.dph_tbl    <= 1'b0;
      st_r.dph_stat   <= 1'b0;
      st_r.dph_mask   <= 1'b0;
      st_r.dph_idx    <= 12'h000;
      st_r.hrdata     <= 32'h0;
      st_r.hready_o   <= 1'b1;
      st_r.hresp      <= 1'b0;
      st_r.status     <= STAT_RST;
      st_r.mask       <= MASK_RST;
      st_r.irq        <= 1'b0;
      st_r.link_ready <= 1'b0;
      st_r.lrsp       <= '0;
      st_r.preq       <= '0;
      st_r.sz         <= SZ_BYTE;
      st_r.ent        <= '0;
    end else begin
      st_r <= st_nxt; // [RULE9]
    end
  end

  assign hrdata     = st_r.hrdata;
  assign hreadyout  = st_r.hready_o;
  assign hresp      = st_r.hresp;
  assign link_ready = st_r.link_ready;
  assign link_out   = st_r.lrsp;
  assign pci_out    = st_r.preq;
  assign irq        = st_r.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_berr_on_invalid: assert property (take && lk_ent.invalid |=> // [RULE8]
      link_out.berr && !pci_out.req && link_ready)
    else $error("invalid page did not end in bus error");

  a_low_bits_pass: assert property (take && !lk_ent.invalid |=> // [RULE3]
      pci_out.addr[11:2] == $past(link_in.addr[11:2]))
    else $error("low address bits changed");

  a_low_bits_keep: assert property (take && !lk_ent.invalid && // [RULE3]
      !lk_ent.swap_b && !lk_ent.wswap |=>
      pci_out.addr[1:0] == $past(link_in.addr[1:0]))
    else $error("address bits 1..0 changed with no swap set");

  a_page_compose: assert property (take && !lk_ent.invalid |=> // [RULE14]
      pci_out.req && pci_out.addr[31:12] == $past(lk_ent.page))
    else $error("upper pci address not from entry");

  a_write_flag: assert property (take && !lk_ent.invalid |=> // [RULE6]
      pci_out.write == $past(link_in.write))
    else $error("pci direction differs from link request");

  a_be_long: assert property (take && !lk_ent.invalid && // [RULE6]
      link_in.size == SZ_LONG |=> pci_out.be == 4'hf)
    else $error("longword access lost a byte lane");

  a_pci_hold: assert property (pci_out.req && !pci_in.done |=> pci_out.req && // [RULE6]
      $stable(pci_out.addr) && $stable(pci_out.wdata) && $stable(pci_out.be))
    else $error("pci request changed before completion");

  a_one_outstanding: assert property (pci_out.req |-> !link_ready) // [RULE17]
    else $error("link ready while pci access open");

  a_ack_ready: assert property (link_out.ack |-> link_ready) // [RULE17]
    else $error("link not ready again with completion");

  a_ack_after_done: assert property (pci_out.req && pci_in.done |=> // [RULE6]
      link_out.ack && !pci_out.req ##1 !link_out.ack)
    else $error("completion not returned in one cycle");

  a_hresp_okay: assert property (hreadyout && !hresp) // [RULE16]
    else $error("register bus stalled or answered error");

  a_tbl_reserved: assert property (hsel && htrans[1] && hready && !hwrite && // [RULE13]
      haddr >= TBL_BASE && haddr <= TBL_LAST |=> hrdata[11:4] == 8'h00)
    else $error("reserved entry bits read nonzero");

  a_word_a1_flip: assert property (take && !lk_ent.invalid && // [RULE11]
      link_in.size == SZ_WORD && lk_ent.wswap |=>
      pci_out.addr[1] != $past(link_in.addr[1]))
    else $error("word swap did not invert a1");

  a_byte_a0_flip: assert property (take && !lk_ent.invalid && // [RULE12]
      link_in.size == SZ_BYTE && lk_ent.swap_b |=>
      pci_out.addr[0] != $past(link_in.addr[0]))
    else $error("byte swap did not move byte lane");

  a_long_swap: assert property (take && !lk_ent.invalid && link_in.write && // [RULE10]
      link_in.size == SZ_LONG && lk_ent.swap_nb |=>
      pci_out.wdata == {$past(link_in.wdata[7:0]), $past(link_in.wdata[15:8]),
                        $past(link_in.wdata[23:16]), $past(link_in.wdata[31:24])})
    else $error("longword bytes not reversed");

  a_word_swap: assert property (take && !lk_ent.invalid && link_in.write && // [RULE10]
      link_in.size == SZ_WORD && lk_ent.swap_nb && !lk_ent.wswap |=>
      pci_out.wdata == {$past(link_in.wdata[23:16]), $past(link_in.wdata[31:24]),
                        $past(link_in.wdata[7:0]), $past(link_in.wdata[15:8])})
    else $error("word bytes not swapped");

  a_byte_swap: assert property (take && !lk_ent.invalid && link_in.write && // [RULE12]
      link_in.size == SZ_BYTE && lk_ent.swap_b |=>
      pci_out.wdata == {$past(link_in.wdata[23:16]), $past(link_in.wdata[31:24]),
                        $past(link_in.wdata[7:0]), $past(link_in.wdata[15:8])})
    else $error("byte data not moved to swapped lane");

  a_swap_off: assert property (take && !lk_ent.invalid && link_in.write && // [RULE5]
      !lk_ent.swap_nb && !lk_ent.wswap && !lk_ent.swap_b |=>
      pci_out.wdata == $past(link_in.wdata))
    else $error("data altered with no swap bit set");

  a_irq_level: assert property (irq == |(st_r.status & st_r.mask))
    else $error("irq disagrees with status and mask");

  c_berr: cover property (link_out.berr);
  c_read_done: cover property (pci_out.req && !pci_out.write && pci_in.done);
  c_tbl_write: cover property (st_r.dph_tbl);
  c_irq: cover property ($rose(irq));
  c_word_swap: cover property (take && link_in.size == SZ_WORD && lk_ent.wswap);
endmodule
`default_nettype wire

//--- dv/pci_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module pci_mem_model (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire xlate_pkg::pci_req_t req,
  input  wire logic [3:0]          dly,
  output xlate_pkg::pci_rsp_t      rsp
);
  import xlate_pkg::*;
  logic [3:0] cnt;
  // Programmable wait, so slow targets get exercised too
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      rsp <= '0;
    end else if (req.req && !rsp.done && cnt == dly) begin
      cnt <= 4'h0;
      rsp.done <= 1'b1;
      rsp.rdata <= ~req.addr;
    end else begin
      cnt <= (req.req && !rsp.done) ? cnt + 4'h1 : 4'h0;
      rsp.done <= 1'b0;
      // Data not valid: keep it moving so stale values never pass
      rsp.rdata <= {rsp.rdata[30:0], ~rsp.rdata[31]};
    end
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import xlate_pkg::*;
  logic        mclk, nrst, hsel, hwrite, hrdy, hresp, irq, link_ready, rdy1;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0]  dly;
  link_req_t   lreq;
  link_rsp_t   lrsp, got;
  pci_req_t    preq, cap;
  pci_rsp_t    prsp;
  int          error_cnt, check_count, npci;
  page_xlate u_page_xlate (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .link_in(lreq),
    .link_ready(link_ready), .link_out(lrsp), .pci_out(preq), .pci_in(prsp), .irq(irq));
  pci_mem_model u_pci_mem_model (.mclk(mclk), .nrst(nrst), .req(preq), .dly(dly),
    .rsp(prsp));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Mid-cycle sampling keeps clear of the launching edge
  always @(negedge mclk) if (preq.req === 1'b1) begin
    cap <= preq;
    npci++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      error_cnt++;
      $display("MISMATCH wait expected under 40 seen %0d", n);
      wrap_up();
    end
  endtask
  task automatic wrdy();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (hrdy === 1'b1) break;
    end
    tmo(n);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wrdy();
    rd = hrdata;
  endtask
  task automatic lnk(input logic wr, input xfer_size_t sz, input logic [31:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk);
    lreq <= '{valid: 1'b1, write: wr, size: sz, addr: a, wdata: wd};
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (link_ready === 1'b1) break;
    end
    tmo(n);
    lreq.valid <= 1'b0;
    lreq.addr <= ~a;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (n == 0) rdy1 = link_ready;
      if (lrsp.ack === 1'b1 || lrsp.berr === 1'b1) break;
    end
    tmo(n);
    got = lrsp;
  endtask
  task automatic t_regs();
    ahb(0, IRQ_MASK_OFS, 32'h0);
    chk("mask_rst", rd, {30'h0, MASK_RST});
    ahb(1, TBL_BASE + 32'h14, 32'hffff_ffff);
    ahb(0, TBL_BASE + 32'h14, 32'h0);
    chk("entry5", rd, 32'hffff_f00f);
    ahb(1, TBL_LAST - 32'h3, 32'h1234_5000);
    ahb(0, TBL_LAST - 32'h3, 32'h0);
    chk("entry4095", rd, 32'h1234_5000);
    ahb(1, 32'h0000_4000, 32'h5555_5555);
    ahb(0, 32'h0000_4000, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_xlate();
    dly <= 4'h3;
    ahb(1, TBL_BASE + 32'h2800, 32'h0080_0ff0);
    lnk(0, SZ_LONG, 32'h40a0_0ab8, 32'h0);
    chk("busy", {31'h0, rdy1}, 32'h0);
    chk("pci_addr", cap.addr, 32'h0080_0ab8);
    chk("pci_be", {28'h0, cap.be}, 32'hf);
    chk("pci_wr", {31'h0, cap.write}, 32'h0);
    chk("ack", {31'h0, got.ack}, 32'h1);
    chk("rdata", got.rdata, 32'hff7f_f547);
    $display("test xlate done");
  endtask
  task automatic t_swap();
    logic [3:0]  bits [5] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h0};
    xfer_size_t  sz [5] = '{SZ_LONG, SZ_WORD, SZ_BYTE, SZ_WORD, SZ_WORD};
    logic [31:0] va [5] = '{32'h1010, 32'h1012, 32'h1011, 32'h1010, 32'h1012};
    logic [31:0] wd [5] = '{32'h1122_3344, 32'h5566_0000, 32'h7700, 32'haabb, 32'h1234_0000};
    logic [31:0] pa [5] = '{32'h0abc_d010, 32'h0abc_d010, 32'h0abc_d010, 32'h0abc_d010,
                            32'h0abc_d012};
    logic [31:0] pd [5] = '{32'h4433_2211, 32'h5566, 32'h77, 32'hbbaa, 32'h1234_0000};
    logic [3:0]  be [5] = '{4'hf, 4'h3, 4'h1, 4'h3, 4'hc};
    dly <= 4'h0;
    for (int i = 0; i < 5; i++) begin
      ahb(1, TBL_BASE + 32'h4, 32'h0abc_d000 | {28'h0, bits[i]});
      lnk(1, sz[i], va[i], wd[i]);
      chk("swap_addr", cap.addr, pa[i]);
      chk("swap_data", cap.wdata, pd[i]);
      chk("swap_be", {28'h0, cap.be}, {28'h0, be[i]});
      chk("swap_wr", {31'h0, cap.write}, 32'h1);
    end
    ahb(1, TBL_BASE + 32'h4, 32'h0abc_d002);
    lnk(0, SZ_LONG, 32'h1010, 32'h0);
    chk("swap_rd", got.rdata, 32'hef2f_43f5);
    $display("test swap done");
  endtask
  task automatic t_irq();
    int n0;
    ahb(1, IRQ_STAT_OFS, 32'h3);
    ahb(1, IRQ_MASK_OFS, 32'h2);
    ahb(1, TBL_BASE + 32'h8, 32'h0abc_e001);
    n0 = npci;
    lnk(0, SZ_LONG, 32'h2000, 32'h0);
    chk("berr", {31'h0, got.berr}, 32'h1);
    chk("no_pci", npci, n0);
    repeat (2) @(posedge mclk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    ahb(0, IRQ_STAT_OFS, 32'h0);
    chk("stat_berr", rd, 32'h2);
    ahb(1, IRQ_STAT_OFS, 32'h2);
    ahb(1, TBL_BASE + 32'h8, 32'h0abc_e000);
    lnk(0, SZ_LONG, 32'h2000, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    ahb(0, IRQ_STAT_OFS, 32'h0);
    chk("stat_done", rd, 32'h1);
    $display("test irq done");
  endtask
  initial begin
    {nrst, hsel, hwrite, htrans, haddr, hwdata, dly} = 73'h0;
    lreq = '0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_xlate();
    t_swap();
    t_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
